// ===== rtl/fimd_datapath.sv
/*
  Execution datapath for four instructions: insert into the top field,
  insert into the low field, set masked bits to the aux flag, set masked
  bits to the inverted aux flag. Holds its own register memory and the
  null and aux flags; all of it is reached over an APB slave.
  Assumes a single clock pclk, an APB master that keeps to the protocol,
  and a power-of-two DEPTH.
  Every access but a status read or write waits while an instruction runs.

  // Function
  // - top field insert writes bits 31..23
  // - low field insert writes bits 8..0
  // - source is register or 9-bit immediate
  // - decode opcode, destination and source fields
  // - masked bits take the aux flag
  // - masked bits take inverted aux flag
  // - mask ops: null on zero, aux parity
  // - insert ops: null flag on zero result
  // - insert null flag follows result, not source
  // - no_writeback keeps destination, flags still update
  // - every instruction completes in four clocks
  // - stale instruction runs if modified too late
*/
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`include "fimd_map.svh"

module fimd_datapath #(
   parameter int DEPTH = `FIMD_DEPTH,
   parameter int EXEC_CLOCKS = `FIMD_EXEC_CLOCKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`FIMD_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic exec_busy
);

   localparam int IW = $clog2(DEPTH);
   localparam int CW = $clog2(EXEC_CLOCKS + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(EXEC_CLOCKS - 1);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   fimd_pkg::fimd_word_t mem_q [DEPTH];

   fimd_pkg::fimd_state_e state_q;
   fimd_pkg::fimd_state_e state_d;
   logic [CW-1:0] cnt_q;
   fimd_pkg::fimd_word_t instr_q;
   fimd_pkg::fimd_word_t dst_val_q;
   fimd_pkg::fimd_word_t src_val_q;
   fimd_pkg::fimd_word_t result_q;
   logic null_q;
   logic aux_q;
   logic bad_op_q;
   logic rd_ok_q;
   logic [31:0] prdata_q;

   // bus decode
   logic hit_instr;
   logic hit_flags;
   logic hit_status;
   logic hit_mem;
   logic mapped;
   logic busy;
   logic stall;
   logic wr_fire;
   logic issue;
   logic rd_ok_d;
   logic flags_wr;
   logic [IW-1:0] mem_idx;

   assign hit_instr = (paddr == `FIMD_OFS_INSTR);
   assign hit_flags = (paddr == `FIMD_OFS_FLAGS);
   assign hit_status = (paddr == `FIMD_OFS_STATUS);
   assign hit_mem = (paddr[11:8] == `FIMD_MEM_PAGE) && (int'(paddr[7:2]) < DEPTH);
   assign mapped = hit_instr | hit_flags | hit_status | hit_mem;
   assign mem_idx = paddr[2 +: IW];
   assign busy = (state_q != fimd_pkg::st_idle);
   // status stays readable while an instruction runs; all else waits
   assign stall = busy & ~hit_status;
   assign pready = psel & penable & rd_ok_q & ~stall;
   assign pslverr = pready & ~mapped;
   assign wr_fire = pready & pwrite & mapped;
   assign issue = wr_fire & hit_instr;
   assign flags_wr = wr_fire & hit_flags;
   // a completing access does not re-arm ready for the next cycle
   assign rd_ok_d = psel & ~stall & ~pready;
   assign exec_busy = busy;
   assign prdata = prdata_q;

   // instruction field decode
   logic [5:0] op;
   logic want_null;
   logic want_aux;
   logic want_wb;
   logic use_imm;
   logic [3:0] cond;
   logic [`FIMD_FIELD_W-1:0] dst_field;
   logic [`FIMD_FIELD_W-1:0] src_field;
   logic [IW-1:0] dst_idx;
   logic [IW-1:0] src_idx;
   logic is_top;
   logic is_low;
   logic is_mux;
   logic is_muxn;
   logic known_op;
   logic runs;

   assign op = instr_q[`FIMD_OP_HI:`FIMD_OP_LO];
   assign want_null = instr_q[`FIMD_BIT_NULLF];
   assign want_aux = instr_q[`FIMD_BIT_AUXF];
   assign want_wb = instr_q[`FIMD_BIT_WB];
   assign use_imm = instr_q[`FIMD_BIT_IMM];
   assign cond = instr_q[`FIMD_COND_HI:`FIMD_COND_LO];
   assign dst_field = instr_q[`FIMD_DST_HI:`FIMD_DST_LO];
   assign src_field = instr_q[`FIMD_SRC_HI:`FIMD_SRC_LO];
   assign dst_idx = dst_field[IW-1:0];
   assign src_idx = src_field[IW-1:0];
   assign is_top = (op == `FIMD_OP_TOP);
   assign is_low = (op == `FIMD_OP_LOW);
   assign is_mux = (op == `FIMD_OP_MUX);
   assign is_muxn = (op == `FIMD_OP_MUXN);
   assign known_op = is_top | is_low | is_mux | is_muxn;
   // other condition codes retire with no effect
   assign runs = known_op & (cond == `FIMD_COND_ALWAYS);

   // sequencer phase strobes
   logic in_fetch;
   logic in_calc;
   logic in_commit;
   assign in_fetch = (state_q == fimd_pkg::st_fetch);
   assign in_calc = (state_q == fimd_pkg::st_calc);
   assign in_commit = (state_q == fimd_pkg::st_commit);

   // operand selection
   fimd_pkg::fimd_word_t src_sel;
   assign src_sel = use_imm ? {{(32 - `FIMD_FIELD_W){1'b0}}, src_field}
                            : mem_q[src_idx];

   // result computation
   fimd_pkg::fimd_word_t res_top;
   fimd_pkg::fimd_word_t res_low;
   fimd_pkg::fimd_word_t mux_fill;
   fimd_pkg::fimd_word_t res_mux;
   fimd_pkg::fimd_word_t res_d;

   assign res_top = {src_val_q[`FIMD_FIELD_W-1:0],
                     dst_val_q[`FIMD_TOP_LO-1:0]};
   assign res_low = {dst_val_q[31:`FIMD_FIELD_W],
                     src_val_q[`FIMD_FIELD_W-1:0]};
   // fill is aux or its inverse, spread over all bits
   assign mux_fill = is_muxn ? {32{~aux_q}} : {32{aux_q}};
   assign res_mux = (dst_val_q & ~src_val_q) | (mux_fill & src_val_q);
   assign res_d = is_top ? res_top :
                  is_low ? res_low :
                  res_mux;

   // flag results
   logic commit;
   logic set_null;
   logic set_aux;
   logic null_res;
   logic aux_res;

   assign commit = in_commit & runs;
   // insert ops judge the written result, not the source value
   assign null_res = (result_q == `FIMD_WORD_RST);
   assign aux_res = ^result_q;
   assign set_null = commit & want_null;
   // insert ops leave the aux flag alone
   assign set_aux = commit & want_aux & (is_mux | is_muxn);

   // memory write port, shared by bus and commit
   logic mem_we;
   logic mem_wr_bus;
   logic mem_wr_exec;
   logic [IW-1:0] wr_idx;
   logic [3:0] wr_be;
   fimd_pkg::fimd_word_t wr_src;
   fimd_pkg::fimd_word_t wr_word;

   assign mem_wr_bus = wr_fire & hit_mem;
   assign mem_wr_exec = commit & want_wb;
   assign mem_we = mem_wr_bus | mem_wr_exec;
   assign wr_idx = busy ? dst_idx : mem_idx;
   assign wr_be = busy ? 4'hF : pstrb;
   assign wr_src = busy ? result_q : pwdata;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign wr_word[8*b +: 8] = wr_be[b] ? wr_src[8*b +: 8]
                                             : mem_q[wr_idx][8*b +: 8];
      end
   endgenerate

   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem_q[wr_idx] <= wr_word;
      end
   end

   // read data mux
   fimd_pkg::fimd_word_t flags_word;
   fimd_pkg::fimd_word_t status_word;
   fimd_pkg::fimd_word_t rd_mux;

   always_comb begin
      flags_word = `FIMD_WORD_RST;
      flags_word[`FIMD_FLAG_NULL] = null_q;
      flags_word[`FIMD_FLAG_AUX] = aux_q;
      status_word = `FIMD_WORD_RST;
      status_word[`FIMD_ST_BUSY] = busy;
      status_word[`FIMD_ST_BADOP] = bad_op_q;
   end

   assign rd_mux = hit_instr ? instr_q :
                   hit_flags ? flags_word :
                   hit_status ? status_word :
                   hit_mem ? mem_q[mem_idx] :
                   `FIMD_WORD_RST;

   // read data is captured one cycle before pready rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= `FIMD_WORD_RST;
         rd_ok_q <= 1'b0;
      end else begin
         rd_ok_q <= rd_ok_d;
         if (psel) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         fimd_pkg::st_idle: begin
            if (issue) begin
               state_d = fimd_pkg::st_fetch;
            end
         end
         fimd_pkg::st_fetch: begin
            state_d = fimd_pkg::st_calc;
         end
         fimd_pkg::st_calc: begin
            state_d = fimd_pkg::st_settle;
         end
         fimd_pkg::st_settle: begin
            if (cnt_q >= CNT_LAST) begin
               state_d = fimd_pkg::st_commit;
            end
         end
         fimd_pkg::st_commit: begin
            state_d = fimd_pkg::st_idle;
         end
         default: begin
            state_d = fimd_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= fimd_pkg::st_idle;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         if (issue) begin
            cnt_q <= CNT_ONE;
         end else if (in_commit) begin
            cnt_q <= '0;
         end else if (busy) begin
            cnt_q <= cnt_q + CNT_ONE;
         end
      end
   end

   // instruction word is taken whole at issue; later edits do not reach it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_q <= `FIMD_INSTR_RST;
      end else if (issue) begin
         instr_q <= pwdata;
      end
   end

   // operand fetch and result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dst_val_q <= `FIMD_WORD_RST;
         src_val_q <= `FIMD_WORD_RST;
         result_q <= `FIMD_WORD_RST;
      end else if (in_fetch) begin
         dst_val_q <= mem_q[dst_idx];
         src_val_q <= src_sel;
      end else if (in_calc) begin
         result_q <= res_d;
      end
   end

   // flags: bus writes only while idle, execution only at commit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         null_q <= `FIMD_FLAG_RST;
         aux_q <= `FIMD_FLAG_RST;
      end else if (flags_wr) begin
         null_q <= pwdata[`FIMD_FLAG_NULL];
         aux_q <= pwdata[`FIMD_FLAG_AUX];
      end else begin
         if (set_null) begin
            null_q <= null_res;
         end
         if (set_aux) begin
            aux_q <= aux_res;
         end
      end
   end

   // sticky unknown-opcode bit, write one to clear, set wins
   logic bad_set;
   logic bad_clr;
   assign bad_set = in_fetch & ~known_op;
   assign bad_clr = wr_fire & hit_status & pwdata[`FIMD_ST_BADOP];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_op_q <= 1'b0;
      end else if (bad_set) begin
         bad_op_q <= 1'b1;
      end else if (bad_clr) begin
         bad_op_q <= 1'b0;
      end
   end

endmodule

// ===== rtl/fimd_map.svh
/*
  Register offsets, instruction word fields, opcodes, reset values and
  timing counts of the field-insert / mask datapath.
  Assumes a 12-bit APB byte address and a 32-bit instruction word.
*/
`ifndef FIMD_MAP_SVH
`define FIMD_MAP_SVH

`define FIMD_ADDR_W 12
`define FIMD_OFS_INSTR 12'h000
`define FIMD_OFS_FLAGS 12'h004
`define FIMD_OFS_STATUS 12'h008
`define FIMD_MEM_PAGE 4'h1

`define FIMD_OP_HI 31
`define FIMD_OP_LO 26
`define FIMD_BIT_NULLF 25
`define FIMD_BIT_AUXF 24
`define FIMD_BIT_WB 23
`define FIMD_BIT_IMM 22
`define FIMD_COND_HI 21
`define FIMD_COND_LO 18
`define FIMD_DST_HI 17
`define FIMD_DST_LO 9
`define FIMD_SRC_HI 8
`define FIMD_SRC_LO 0

`define FIMD_OP_TOP 6'h16
`define FIMD_OP_LOW 6'h14
`define FIMD_OP_MUX 6'h1C
`define FIMD_OP_MUXN 6'h1D
`define FIMD_COND_ALWAYS 4'hF

`define FIMD_FIELD_W 9
`define FIMD_TOP_LO 23
`define FIMD_LOW_LO 0

`define FIMD_FLAG_NULL 0
`define FIMD_FLAG_AUX 1
`define FIMD_ST_BUSY 0
`define FIMD_ST_BADOP 1

`define FIMD_INSTR_RST 32'h0000_0000
`define FIMD_WORD_RST 32'h0000_0000
`define FIMD_FLAG_RST 1'b0

`define FIMD_EXEC_CLOCKS 4
`define FIMD_DEPTH 16

`endif

// ===== rtl/fimd_pkg.sv
/*
  Types shared by the field-insert / mask datapath.
  Assumes nothing of its surroundings.
*/
package fimd_pkg;

   typedef logic [31:0] fimd_word_t;

   typedef enum logic [2:0] {
      st_idle,
      st_fetch,
      st_calc,
      st_settle,
      st_commit
   } fimd_state_e;

endpackage

// ===== dv/fimd_datapath_properties.sv
/*
  Checker of the APB handshake and execution timing of the datapath.
  Assumes it is bound to fimd_datapath and sees only its ports.
*/
`timescale 1ns/10ps
`include "fimd_map.svh"

module fimd_datapath_props #(
   parameter int DEPTH = 16,
   parameter int EXEC_CLOCKS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`FIMD_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic exec_busy
);
   wire acc = psel && penable;
   wire issue = acc && pready && pwrite && (paddr == `FIMD_OFS_INSTR);
   wire stat = paddr == `FIMD_OFS_STATUS;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_busy_len: assert property ($rose(exec_busy) |-> exec_busy [*4] ##1 !exec_busy)
      else $error("busy span is not four cycles");
   a_issue_start: assert property (issue |=> exec_busy)
      else $error("instruction write did not start execution");
   a_busy_cause: assert property ($rose(exec_busy) |-> $past(issue))
      else $error("execution started without an instruction write");
   a_busy_stall: assert property (acc && exec_busy && !stat |-> !pready)
      else $error("access answered while executing");
   a_status_fast: assert property (acc && stat |-> pready)
      else $error("status read was stalled");
   a_err_ready: assert property (pslverr |-> pready && acc)
      else $error("error without a completing access");
   a_unmapped_err: assert property (acc && paddr == 12'h00C |-> pslverr == pready)
      else $error("unmapped access not refused");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   cover property (issue);
   cover property (acc && pslverr);
   cover property (acc && exec_busy && !pready);
endmodule

bind fimd_datapath fimd_datapath_props #(.DEPTH(DEPTH), .EXEC_CLOCKS(EXEC_CLOCKS))
   i_fimd_datapath_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy));

// ===== dv/fimd_apb_host.sv
/*
  APB master standing in for the core side that issues instructions.
  Assumes one clock pclk; waits on pready with no fixed latency.
*/
`timescale 1ns/10ps

module fimd_apb_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ===== dv/test_field_insert_mask_mux_datapath.sv
/*
  Testbench: runs each instruction through the APB registers and checks
  result word and flags. Assumes the host model and the bound checker.
*/
`timescale 1ns/10ps
`include "fimd_map.svh"

module test_field_insert_mask_mux_datapath;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, exec_busy, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   fimd_pkg::fimd_word_t rd;
   int mismatches = 0;
   int tests_run = 0;

   always #50 pclk = ~pclk;

   fimd_datapath i_fimd_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy));
   fimd_apb_host i_fimd_apb_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   task automatic chk(input fimd_pkg::fimd_word_t g, input fimd_pkg::fimd_word_t e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // word 1 is the destination, word 2 the register source; ef = null, aux, write
   task automatic run(input logic [5:0] op, input logic [2:0] ef, input logic im,
      input fimd_pkg::fimd_word_t d, input fimd_pkg::fimd_word_t s, input logic [1:0] fi,
      input fimd_pkg::fimd_word_t ex, input logic [1:0] fx);
      i_fimd_apb_host.xfer(1'b1, 12'h104, d, rd, er);
      i_fimd_apb_host.xfer(1'b1, 12'h108, im ? ~s : s, rd, er);
      i_fimd_apb_host.xfer(1'b1, `FIMD_OFS_FLAGS, {30'h0, fi}, rd, er);
      i_fimd_apb_host.xfer(1'b1, `FIMD_OFS_INSTR,
         {op, ef, im, `FIMD_COND_ALWAYS, 9'h001, im ? s[8:0] : 9'h002}, rd, er);
      i_fimd_apb_host.xfer(1'b0, `FIMD_OFS_STATUS, 32'h0, rd, er);
      chk({31'h0, rd[0]}, 32'h1);
      i_fimd_apb_host.xfer(1'b0, 12'h104, 32'h0, rd, er);
      chk(rd, ex);
      i_fimd_apb_host.xfer(1'b0, `FIMD_OFS_FLAGS, 32'h0, rd, er);
      chk(rd, {30'h0, fx});
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      $display("Error at %0t: timeout", $time);
      mismatches++;
      final_report;
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      run(6'h16, 3'h7, 1'b0, 32'h0, 32'h1FF, 2'h2, 32'hFF80_0000, 2'h2);
      run(6'h16, 3'h7, 1'b0, 32'hFFFF_FFFF, 32'h0, 2'h1, 32'h007F_FFFF, 2'h0);
      run(6'h16, 3'h7, 1'b0, 32'h0, 32'h0, 2'h0, 32'h0, 2'h1);
      run(6'h14, 3'h7, 1'b1, 32'hFFFF_FFFF, 32'h0, 2'h0, 32'hFFFF_FE00, 2'h0);
      run(6'h14, 3'h7, 1'b1, 32'h0, 32'h1FF, 2'h2, 32'h1FF, 2'h2);
      run(6'h1C, 3'h7, 1'b0, 32'hAA55_2200, 32'h1234_5678, 2'h2, 32'hBA75_7678, 2'h2);
      run(6'h1C, 3'h7, 1'b0, 32'hAA55_2200, 32'h1234_5678, 2'h0, 32'hA841_2000, 2'h0);
      run(6'h1C, 3'h7, 1'b0, 32'hAA55_2200, 32'hFFFF_FFFF, 2'h0, 32'h0, 2'h1);
      run(6'h1D, 3'h7, 1'b1, 32'h0, 32'h1, 2'h0, 32'h1, 2'h2);
      run(6'h1D, 3'h7, 1'b0, 32'hAA55_2200, 32'hFFFF_FFFF, 2'h2, 32'h0, 2'h1);
      run(6'h1C, 3'h6, 1'b0, 32'h0, 32'h3, 2'h2, 32'h0, 2'h0);
      run(6'h1C, 3'h1, 1'b0, 32'h0, 32'h1, 2'h3, 32'h1, 2'h3);
      i_fimd_apb_host.xfer(1'b0, 12'h00C, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      // read straight after issue waits for the commit
      i_fimd_apb_host.xfer(1'b1, 12'h104, 32'h0, rd, er);
      i_fimd_apb_host.xfer(1'b1, 12'h108, 32'hF0, rd, er);
      i_fimd_apb_host.xfer(1'b1, `FIMD_OFS_FLAGS, 32'h2, rd, er);
      i_fimd_apb_host.xfer(1'b1, `FIMD_OFS_INSTR,
         {6'h1C, 3'h1, 1'b0, `FIMD_COND_ALWAYS, 9'h001, 9'h002}, rd, er);
      i_fimd_apb_host.xfer(1'b0, 12'h104, 32'h0, rd, er);
      chk(rd, 32'hF0);
      // a condition other than always retires with no effect
      i_fimd_apb_host.xfer(1'b1, `FIMD_OFS_INSTR,
         {6'h1D, 3'h7, 1'b0, 4'h0, 9'h001, 9'h002}, rd, er);
      i_fimd_apb_host.xfer(1'b0, 12'h104, 32'h0, rd, er);
      chk(rd, 32'hF0);
      i_fimd_apb_host.xfer(1'b0, `FIMD_OFS_FLAGS, 32'h0, rd, er);
      chk(rd, 32'h2);
      // unknown opcode: no effect, sticky status bit, cleared by writing one
      i_fimd_apb_host.xfer(1'b1, `FIMD_OFS_INSTR,
         {6'h3F, 3'h7, 1'b0, `FIMD_COND_ALWAYS, 9'h001, 9'h002}, rd, er);
      i_fimd_apb_host.xfer(1'b0, `FIMD_OFS_STATUS, 32'h0, rd, er);
      chk(rd, 32'h3);
      i_fimd_apb_host.xfer(1'b0, 12'h104, 32'h0, rd, er);
      chk(rd, 32'hF0);
      i_fimd_apb_host.xfer(1'b1, `FIMD_OFS_STATUS, 32'h2, rd, er);
      i_fimd_apb_host.xfer(1'b0, `FIMD_OFS_STATUS, 32'h0, rd, er);
      chk(rd, 32'h0);
      final_report;
   end
endmodule
